// *** logic/twes_eeprom.sv ***
// two-wire bus slave of a 256 byte memory with page write
// assumes linkClk oversamples scl/sda at least ten times per bit
//
// Overview of operation
// - answer only when low address bits match straps
// - write-direction address, next byte loads pointer
// - received data bytes latched, page holds eight max
// - acknowledge address, word address, every data byte the fifo accepts
// - write cycle after stop, ten ms per byte
// - data byte bumps low three pointer bits only
// - more than eight bytes wrap within page
// - bus ignored while write cycle runs
// - random read: address write, restart, read direction
// - send pointer byte, advance only on master ack
// - keep sending consecutive bytes until master nack
// - bare read starts at stored pointer
// - start/stop are sda edges while scl high
// - ninth clock carries the acknowledge low
// - master nack ends read, sda released high
`timescale 1ns/100ps
`default_nettype none
`include "twes_regs.svh"
module twes_eeprom #(
  parameter logic [3:0] deviceType = 4'ha, // arbitrary value
  parameter int writeCycles = `TWES_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire twes_pkg::twes_straps_type chipSelectStraps,
  output logic writeBusy
);
  import twes_pkg::*;

  // ************************************************************
  // link side input sampling
  // ************************************************************
  logic [6:0] linkSync;
  logic busyRef, ackToggle;
  logic sclPrev, sdaPrev, ackPrev;

  twes_sync #(.WIDTH(7)) u_linkSync (
    .clk(linkClk),
    .nrst(nrst),
    .din({sclIn, sdaIn, chipSelectStraps, busyRef, ackToggle}),
    .dout(linkSync)
  );

  wire sclS = linkSync[6];
  wire sdaS = linkSync[5];
  wire [2:0] strapS = linkSync[4:2];
  wire busyS = linkSync[1];
  wire ackS = linkSync[0];

  // idle bus is high, so the history starts high to avoid false edges
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      ackPrev <= 1'b0;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      ackPrev <= ackS;
    end
  end

  // bus conditions from the synced lines
  wire sclRise = sclS & ~sclPrev;
  wire sclFall = ~sclS & sclPrev;
  wire startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopCond = sclS & sclPrev & ~sdaPrev & sdaS;
  wire ackEdge = ackS ^ ackPrev;

  // ************************************************************
  // link side sequencer
  // ************************************************************
  twes_state_type st, next_st;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shiftReg, next_shift, txShift, next_tx;
  logic [7:0] pointer, next_ptr, reqAddr, next_reqAddr, rdData;
  logic [7:0] respData;
  logic sdaLow, next_sdaLow, dataSeen, next_dataSeen;
  logic busySeen, next_busySeen, markSent, next_markSent;
  logic reqToggle, next_req, pushValid, pushMark, fifoInReady;

  wire byteDone = bitCnt == 4'h8;
  wire rxState = st == S_DEVADDR || st == S_WORDADDR || st == S_WRDATA;
  wire typeMatch = shiftReg[7:`TWES_TYPE_POS] == deviceType;
  wire strapMatch = shiftReg[3:`TWES_STRAP_POS] == strapS;
  wire devMatch = typeMatch & strapMatch;
  wire readDir = shiftReg[`TWES_RW_POS];
  wire [7:0] ptrInc = pointer + 8'h01;
  wire [`TWES_ENTRY_W-1:0] pushData = {pushMark, pointer, shiftReg};

  // open drain: the line is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaLow;

  always_comb begin
    next_st = st;
    next_bitCnt = bitCnt;
    next_shift = shiftReg;
    next_tx = txShift;
    next_ptr = pointer;
    next_reqAddr = reqAddr;
    next_sdaLow = sdaLow;
    next_dataSeen = dataSeen;
    next_busySeen = busySeen;
    next_markSent = markSent;
    next_req = reqToggle;
    pushValid = 1'b0;
    pushMark = 1'b0;
    // data is sampled on the rising clock edge
    if (rxState && sclRise) begin
      next_shift = {shiftReg[6:0], sdaS};
      next_bitCnt = bitCnt + 4'h1;
    end
    case (st)
      S_IDLE: begin
      end
      S_DEVADDR: begin
        if (byteDone && sclFall) begin
          if (devMatch) begin
            next_sdaLow = 1'b1;
            next_st = S_ACK_DEV;
            // prefetch from the held pointer for a read
            if (readDir) begin
              next_req = ~reqToggle;
              next_reqAddr = pointer;
            end
          end else begin
            next_st = S_IDLE;
          end
        end
      end
      S_ACK_DEV: begin
        if (sclFall) begin
          next_bitCnt = 4'h0;
          if (readDir) begin
            next_tx = rdData;
            next_sdaLow = ~rdData[7];
            next_st = S_RDDATA;
          end else begin
            next_sdaLow = 1'b0;
            next_st = S_WORDADDR;
          end
        end
      end
      S_WORDADDR: begin
        if (byteDone && sclFall) begin
          next_ptr = shiftReg;
          next_sdaLow = 1'b1;
          next_st = S_ACK_WORD;
        end
      end
      S_ACK_WORD, S_ACK_WR: begin
        if (sclFall) begin
          next_sdaLow = 1'b0;
          next_bitCnt = 4'h0;
          next_st = S_WRDATA;
        end
      end
      S_WRDATA: begin
        // a full crossing fifo refuses the byte with a nack
        if (byteDone && sclFall) begin
          if (fifoInReady) begin
            pushValid = 1'b1;
            next_ptr = {pointer[7:3], ptrInc[2:0]};
            next_dataSeen = 1'b1;
            next_sdaLow = 1'b1;
            next_st = S_ACK_WR;
          end else begin
            next_st = S_IDLE;
          end
        end
      end
      S_RDDATA: begin
        if (sclRise) begin
          next_bitCnt = bitCnt + 4'h1;
        end
        if (sclFall) begin
          if (byteDone) begin
            next_sdaLow = 1'b0;
            next_st = S_RDACK;
          end else begin
            next_tx = {txShift[6:0], 1'b0};
            next_sdaLow = ~txShift[6];
          end
        end
      end
      S_RDACK: begin
        if (sclRise) begin
          if (!sdaS) begin
            next_ptr = ptrInc;
            next_reqAddr = ptrInc;
            next_req = ~reqToggle;
            next_st = S_RDNEXT;
          end else begin
            next_st = S_IDLE;
          end
        end
      end
      S_RDNEXT: begin
        // the fetch has the high phase of the ack clock on scl to return
        if (sclFall) begin
          next_bitCnt = 4'h0;
          next_tx = rdData;
          next_sdaLow = ~rdData[7];
          next_st = S_RDDATA;
        end
      end
      S_COMMIT: begin
        if (!markSent && fifoInReady) begin
          pushValid = 1'b1;
          pushMark = 1'b1;
          next_markSent = 1'b1;
        end
        if (busyS) begin
          next_busySeen = 1'b1;
        end
        if (busySeen && !busyS) begin
          next_busySeen = 1'b0;
          next_dataSeen = 1'b0;
          next_st = S_IDLE;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
    // start and stop act anywhere except during the write cycle
    if (st != S_COMMIT) begin
      if (stopCond) begin
        next_sdaLow = 1'b0;
        next_markSent = 1'b0;
        next_st = dataSeen ? S_COMMIT : S_IDLE;
      end else if (startCond) begin
        next_sdaLow = 1'b0;
        next_bitCnt = 4'h0;
        next_st = S_DEVADDR;
      end
    end
  end

  // sequencer registers; the pointer survives between transfers
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      st <= S_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      txShift <= 8'h00;
      pointer <= 8'h00;
      reqAddr <= 8'h00;
      sdaLow <= 1'b0;
      dataSeen <= 1'b0;
      busySeen <= 1'b0;
      markSent <= 1'b0;
      reqToggle <= 1'b0;
    end else begin
      st <= next_st;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shift;
      txShift <= next_tx;
      pointer <= next_ptr;
      reqAddr <= next_reqAddr;
      sdaLow <= next_sdaLow;
      dataSeen <= next_dataSeen;
      busySeen <= next_busySeen;
      markSent <= next_markSent;
      reqToggle <= next_req;
    end
  end

  // read data is taken only when the answer toggle arrives
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else if (ackEdge) begin
      rdData <= respData;
    end
  end

  // ************************************************************
  // crossing of write entries
  // ************************************************************
  logic popValid, popReady;
  logic [`TWES_ENTRY_W-1:0] popData;

  twes_async_fifo #(.WIDTH(`TWES_ENTRY_W), .DEPTH(`TWES_FIFO_DEPTH)) u_fifo (
    .wrClk(linkClk),
    .rdClk(ref_clk),
    .nrst(nrst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  // ************************************************************
  // memory side on ref_clk
  // ************************************************************
  logic reqS, reqPrev;
  logic [7:0] mem [`TWES_MEM_BYTES];
  logic [7:0] pageData [`TWES_PAGE_BYTES];
  logic [7:0] pageValid;
  logic [4:0] pageHi;
  logic [3:0] bytesLeft;
  logic [31:0] tick;

  twes_sync #(.WIDTH(1)) u_reqSync (
    .clk(ref_clk),
    .nrst(nrst),
    .din(reqToggle),
    .dout(reqS)
  );

  // the fifo stalls while the array is being programmed
  assign popReady = ~busyRef;
  assign writeBusy = busyRef;
  wire popFire = popValid & popReady;
  wire popMark = popData[`TWES_MARK_POS];
  wire [7:0] popAddr = popData[15:8];
  wire commitNow = popFire & popMark;
  wire dataPop = popFire & ~popMark;
  wire [3:0] pageCount = 4'($countones(pageValid));
  wire tickEnd = tick == 32'(writeCycles - 1);

  // fetch answers; reqAddr is stable while the toggle crosses
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reqPrev <= 1'b0;
      ackToggle <= 1'b0;
      respData <= 8'h00;
    end else begin
      reqPrev <= reqS;
      if (reqS ^ reqPrev) begin
        respData <= mem[reqAddr];
        ackToggle <= ~ackToggle;
      end
    end
  end

  // page buffer slots, last byte to a slot wins
  generate
    for (genvar i = 0; i < `TWES_PAGE_BYTES; i++) begin : g_page
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          pageData[i] <= 8'h00;
          pageValid[i] <= 1'b0;
        end else if (commitNow) begin
          pageValid[i] <= 1'b0;
        end else if (dataPop && popAddr[2:0] == 3'(i)) begin
          pageData[i] <= popData[7:0];
          pageValid[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // page row held from the latest data entry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pageHi <= 5'h00;
    end else if (dataPop) begin
      pageHi <= popAddr[7:3];
    end
  end

  // array cells; reset to the erased value stands in for power-up
  generate
    for (genvar j = 0; j < `TWES_MEM_BYTES; j++) begin : g_mem
      localparam logic [7:0] IDX = 8'(j);
      wire hit = commitNow & (pageHi == IDX[7:3]) & pageValid[IDX[2:0]];
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          mem[j] <= `TWES_ERASED;
        end else if (hit) begin
          mem[j] <= pageData[IDX[2:0]];
        end
      end
    end
  endgenerate

  // write timer: one full slot of writeCycles per byte programmed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busyRef <= 1'b0;
      bytesLeft <= 4'h0;
      tick <= 32'h0;
    end else if (commitNow) begin
      busyRef <= 1'b1;
      bytesLeft <= pageCount;
      tick <= 32'h0;
    end else if (busyRef) begin
      if (tickEnd) begin
        tick <= 32'h0;
        bytesLeft <= bytesLeft - 4'h1;
        busyRef <= bytesLeft > 4'h1;
      end else begin
        tick <= tick + 32'h1;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_NO_MATCH_IDLE: assert property (
    @(posedge linkClk) disable iff (!nrst)
    (st == S_DEVADDR && byteDone && sclFall && !devMatch && !stopCond
     && !startCond) |=> (st == S_IDLE && !sdaLow))
    else $error("unmatched address was acknowledged");
  AST_WORD_LOAD: assert property (
    @(posedge linkClk) disable iff (!nrst)
    (st == S_WORDADDR && byteDone && sclFall && !stopCond && !startCond)
    |=> (pointer == $past(shiftReg) && st == S_ACK_WORD))
    else $error("word address not loaded into pointer");
  AST_DATA_PUSH: assert property (
    @(posedge linkClk) disable iff (!nrst)
    (st == S_WRDATA && byteDone && sclFall && fifoInReady)
    |-> (pushValid && !pushMark))
    else $error("received data byte not stored");
  AST_ACK_HELD: assert property (
    @(posedge linkClk) disable iff (!nrst)
    $rose(st == S_ACK_WORD) |-> sdaLow && !sdaOeN)
    else $error("word address not acknowledged");
  AST_BUSY_AFTER_COMMIT: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    commitNow |=> busyRef && bytesLeft != 4'h0 && tick == 32'h0)
    else $error("write cycle did not start on commit");
  AST_PAGE_WRAP: assert property (
    @(posedge linkClk) disable iff (!nrst)
    (pushValid && !pushMark && !stopCond && !startCond)
    |=> pointer[7:3] == $past(pointer[7:3])
        && pointer[2:0] == 3'($past(pointer[2:0]) + 3'h1))
    else $error("page pointer did not step within page");
  AST_BUS_IGNORED: assert property (
    @(posedge linkClk) disable iff (!nrst)
    (st == S_COMMIT && busyS) |=> st == S_COMMIT && !sdaLow)
    else $error("bus served during write cycle");
  AST_NACK_HOLDS_PTR: assert property (
    @(posedge linkClk) disable iff (!nrst)
    (st == S_RDACK && sclRise && sdaS)
    |=> pointer == $past(pointer) ##1 !sdaLow)
    else $error("pointer moved without master ack");
  AST_TICK_BOUND: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    busyRef |-> tick < 32'(writeCycles) && bytesLeft <= 4'h8)
    else $error("write slot overran its time");

endmodule
`default_nettype wire

// *** include/twes_regs.svh ***
// constants of the two-wire memory slave: sizes, encodings and timing
// assumes the includer runs its register side at the 200 MHz ref_clk
`ifndef TWES_REGS_SVH
`define TWES_REGS_SVH

// ************************************************************
// memory and page geometry
// ************************************************************
`define TWES_MEM_BYTES 256
`define TWES_PAGE_BYTES 8
`define TWES_ERASED 8'hff
`define TWES_TYPE_POS 4
`define TWES_STRAP_POS 1
`define TWES_RW_POS 0

// ************************************************************
// crossing fifo entry: {commit mark, address, data}
// ************************************************************
`define TWES_ENTRY_W 17
`define TWES_FIFO_DEPTH 32
`define TWES_MARK_POS 16

// ************************************************************
// write cycle timing
// ************************************************************
`define TWES_WRITE_TIME_MS 10
`define TWES_REF_CLK_MHZ 200
`define TWES_WRITE_CYCLES (`TWES_WRITE_TIME_MS * `TWES_REF_CLK_MHZ * 1000)

`endif

// *** include/twes_pkg.sv ***
// types shared by the two-wire memory slave files
// assumes twes_regs.svh supplies the numeric constants
package twes_pkg;

  // strap pins giving the low slave address bits
  typedef logic [2:0] twes_straps_type;

  // link side sequencer states
  typedef enum logic [3:0] {
    S_IDLE,
    S_DEVADDR,
    S_ACK_DEV,
    S_WORDADDR,
    S_ACK_WORD,
    S_WRDATA,
    S_ACK_WR,
    S_RDDATA,
    S_RDACK,
    S_RDNEXT,
    S_COMMIT
  } twes_state_type;

endpackage

// *** logic/twes_sync.sv ***
// two flip-flop level synchroniser, one per bit
// assumes each bit is a level that is stable for several dest clocks
`timescale 1ns/100ps
`default_nettype none
module twes_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule
`default_nettype wire

// *** logic/twes_async_fifo.sv ***
// dual clock fifo with gray coded pointers
// assumes DEPTH is a power of two; one reset serves both clocks
`timescale 1ns/100ps
`default_nettype none
module twes_async_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic wrClk,
  input wire logic rdClk,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wrBin, wrGray, rdBin, rdGray, wrGrayS, rdGrayS;

  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  wire [AW:0] next_wrBin = wrBin + (AW+1)'(push);
  wire [AW:0] next_rdBin = rdBin + (AW+1)'(pop);

  // full when write is a whole lap ahead of the synced read pointer
  assign inReady = wrGray != {~rdGrayS[AW:AW-1], rdGrayS[AW-2:0]};
  assign outValid = rdGray != wrGrayS;
  assign outData = store[rdBin[AW-1:0]];

  // storage is written on the filling clock only
  always_ff @(posedge wrClk) begin
    if (push) begin
      store[wrBin[AW-1:0]] <= inData;
    end
  end

  // write pointer
  always_ff @(posedge wrClk or negedge nrst) begin
    if (!nrst) begin
      wrBin <= '0;
      wrGray <= '0;
    end else begin
      wrBin <= next_wrBin;
      wrGray <= next_wrBin ^ (next_wrBin >> 1);
    end
  end

  // read pointer
  always_ff @(posedge rdClk or negedge nrst) begin
    if (!nrst) begin
      rdBin <= '0;
      rdGray <= '0;
    end else begin
      rdBin <= next_rdBin;
      rdGray <= next_rdBin ^ (next_rdBin >> 1);
    end
  end

  twes_sync #(.WIDTH(AW+1)) u_rdToWr (
    .clk(wrClk),
    .nrst(nrst),
    .din(rdGray),
    .dout(rdGrayS)
  );

  twes_sync #(.WIDTH(AW+1)) u_wrToRd (
    .clk(rdClk),
    .nrst(nrst),
    .din(wrGray),
    .dout(wrGrayS)
  );

endmodule
`default_nettype wire

// *** verification/twes_master.sv ***
// bus master model: drives scl, pulls sda low
// assumes the bench resolves both wires with pull-ups
`timescale 1ns/100ps
`default_nettype none
module twes_master #(
  parameter int T = 240
) (
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow
);
  // ****************
  // bus conditions
  // ****************
  // both lines released while idle
  initial begin
    sclLow = 0;
    sdaLow = 0;
  end
  // sda falls with scl high, also a repeated start
  task automatic start;
    sdaLow = 0;
    #(T);
    sclLow = 0;
    #(T);
    sdaLow = 1;
    #(T);
    sclLow = 1;
    #(T/4);
  endtask
  // sda rises with scl high
  task automatic stop;
    sdaLow = 1;
    #(T);
    sclLow = 0;
    #(T);
    sdaLow = 0;
    #(T);
  endtask
  // ****************
  // bits and bytes
  // ****************
  // data moves only while scl low, read mid high
  task automatic bitCk(input logic pull, output logic seen);
    sdaLow = pull;
    #(T);
    sclLow = 0;
    #(T/2);
    seen = sda;
    #(T/2);
    sclLow = 1;
    #(T/4);
  endtask
  // msb first, ninth clock carries the ack
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitCk(!b[i], s);
    bitCk(0, s);
    ack = !s;
  endtask
  // ack to go on, withheld on the last byte
  task automatic recvByte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCk(0, s);
      d[i] = s;
    end
    bitCk(more, s);
  endtask
endmodule
`default_nettype wire

// *** verification/test_two_wire_eeprom_slave.sv ***
// self-checking bench of the two-wire memory slave
// assumes twes_master stands in for the bus master
`timescale 1ns/100ps
`default_nettype none
`include "twes_regs.svh"
module test_two_wire_eeprom_slave;
  import twes_pkg::*;
  // short write cycle keeps the run brief
  localparam int WC = 400;
  localparam logic [3:0] DEV = 4'ha; // arbitrary value
  logic ref_clk, linkClk, nrst, sdaOut, sdaOeN, writeBusy;
  logic sclLow, sdaLow, scl, sda, ack;
  logic [7:0] d;
  logic [7:0] mem [256];
  twes_straps_type straps;
  int failCount, checks, busyCount;
  // ****************
  // clocks, wires, instances
  // ****************
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // link clock kept out of phase with ref_clk
  initial begin
    linkClk = 0;
    #1.3;
    forever #6 linkClk = ~linkClk;
  end
  // open-drain wires with pull-ups
  assign scl = !sclLow;
  assign sda = !(sdaLow || !sdaOeN);
  // busy span in ref_clk cycles, sampled away from the launching edge
  always @(negedge ref_clk) begin
    if (writeBusy === 1'b1) busyCount++;
  end
  twes_eeprom #(.deviceType(DEV), .writeCycles(WC)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .linkClk(linkClk),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .chipSelectStraps(straps), .writeBusy(writeBusy));
  twes_master #(.T(240)) i_host (
    .sda(sda), .sclLow(sclLow), .sdaLow(sdaLow));
  // ****************
  // helpers
  // ****************
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bounded wait; a stuck flag ends the run
  task automatic waitBusy(input logic lvl);
    int n = 0;
    while (writeBusy !== lvl && n < 20000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (writeBusy !== lvl) begin
      check("busy wait", writeBusy, lvl);
      conclude();
    end
  endtask
  // start and slave address with straps and direction
  task automatic open(input logic rw, input logic ex);
    i_host.start();
    i_host.sendByte({DEV, straps, rw}, ack);
    check("addr ack", ack, ex);
  endtask
  // read n bytes from a, nack on the last, then stop
  task automatic readOut(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      i_host.recvByte(i < n - 1, d);
      check("read byte", d, mem[a + i[7:0]]);
    end
    #60;
    check("released", sdaOeN, 1);
    i_host.stop();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic testReset;
    check("oe after reset", sdaOeN, 1);
    check("busy after reset", writeBusy, 0);
    check("sda out", sdaOut, 0);
    $display("test reset done");
  endtask
  // one wrong strap bit each, then a wrong type bit
  task automatic testForeign;
    for (int i = 0; i < 4; i++) begin
      i_host.start();
      i_host.sendByte({DEV ^ {i == 3, 3'h0}, straps ^ (3'h1 << i), 1'b0},
        ack);
      check("foreign ack", ack, 0);
      i_host.stop();
    end
    check("no busy", writeBusy, 0);
    $display("test foreign done");
  endtask
  // ten bytes overrun the page on purpose
  task automatic testPage;
    logic [7:0] p = 8'h2d;
    open(0, 1);
    i_host.sendByte(p, ack);
    check("word ack", ack, 1);
    for (int i = 0; i < 10; i++) begin
      i_host.sendByte(8'h30 + i[7:0], ack);
      check("data ack", ack, 1);
      // low pointer bits wrap in page
      mem[{p[7:3], p[2:0] + i[2:0]}] = 8'h30 + i[7:0];
    end
    check("busy before stop", writeBusy, 0);
    busyCount = 0;
    i_host.stop();
    waitBusy(1);
    open(0, 0);
    i_host.stop();
    waitBusy(0);
    // eight distinct slots were written, one write slot each
    check("busy span", busyCount, 8 * WC);
    repeat (4) @(posedge linkClk);
    $display("test page done");
  endtask
  // pointer sits one past the last written slot
  task automatic testAfterWrite;
    open(1, 1);
    readOut(8'h2f, 1);
    $display("test after write done");
  endtask
  // read crosses the page end
  task automatic testRandom;
    open(0, 1);
    i_host.sendByte(8'h26, ack);
    check("read word ack", ack, 1);
    open(1, 1);
    readOut(8'h26, 10);
    // a stop after a transfer without data starts no write cycle
    repeat (40) @(posedge ref_clk);
    #1;
    check("no busy after read", writeBusy, 0);
    $display("test random done");
  endtask
  // nacked byte left the pointer in place
  task automatic testCurrent;
    open(1, 1);
    readOut(8'h2f, 2);
    $display("test current done");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    nrst = 0;
    straps = 3'h5;
    busyCount = 0;
    foreach (mem[i]) mem[i] = `TWES_ERASED;
    repeat (3) @(posedge linkClk);
    @(posedge ref_clk);
    #1 nrst = 1;
    repeat (10) @(posedge linkClk);
    testReset();
    testForeign();
    testPage();
    testAfterWrite();
    testRandom();
    testCurrent();
    conclude();
  end
endmodule
`default_nettype wire
